// file: adc_command_decoder_config.sv
// Command word decoder and configuration register of the dual ADC.
//
// Operation
// - Six bits below the direction bit of each command word pick the target register.
// - Bit 15 direction, bit 14 address MSB, 13:9 address, 8:0 data.
// - Direction one stores nine payload bits into the addressed channel, range or stack register; config keeps bits 6:0.
// - Direction zero arms the register for the next read, not this one.
// - Address bit 5 set selects one of 32 sequencer stack registers.
// - Low address: 1 reserved, 2 config, 3 channel, 4-7 ranges, 8 status.
// - Read request to address zero returns conversion results next read.
// - Configuration register sits at address two and resets to zero.
// - Config top seven bits echo address; bit 8 reads zero.
// - Config bit 7 is read-only self-detect fail flag.
// - Burst off: one channel pair per convert start pulse.
// - Burst on with sequencer on: one pulse converts stack layers through the end marker.
// - Sequencer off: next conversion follows the channel register.
// - Configuration settings act only in software configuration mode.
// - Sequencer on: conversions step through the stack layers.
// - Config bits 4:2 select oversampling ratio, 000 off up to 128.
// - Status enabled: status word with CRC follows last result word.
// - Checksum enable bit acts exactly like status enable bit.
`timescale 1ns/10ps
`default_nettype none
`include "adc_cmd_cfg.svh"
module adc_command_decoder_config
  import adc_cmd_pkg::*;
(
  input  wire logic        sys_clk,         // 40 MHz clock.
  input  wire logic        nrst,            // Async reset, low.
  input  wire logic        cmd_valid,       // One-cycle strobe with cmd_word.
  input  wire logic [15:0] cmd_word,        // Host command word.
  input  wire logic        read_done,       // A read operation completed.
  input  wire logic        sw_mode,         // Software configuration mode.
  input  wire logic        self_test_fail,  // Power-up self check failed.
  input  wire logic        convert_start_pulse, // Convert request.
  input  wire logic        pair_done,       // Engine finished a pair.
  input  wire logic [7:0]  status_word,     // Status bits and CRC low byte.
  output logic      [15:0] read_data,       // Word for the next read.
  output logic             read_is_results, // Next read returns results.
  output logic      [15:0] main_configuration, // Configuration readback.
  output logic             pair_convert,    // Start one pair conversion.
  output logic      [8:0]  pair_select,     // Selected pair code.
  output logic      [2:0]  oversample_ratio, // Effective ratio code.
  output logic             append_status    // Append status after results.
);
  logic [6:0]  regSel;
  logic        isWrite;
  logic [8:0]  payload;
  logic        cfgWr;
  logic        chanWr;
  logic [3:0]  rangeWr;
  logic [8:0]  chanQ;
  logic [8:0]  rangeQ [4];
  logic [8:0]  stack_ff [`STACK_DEPTH];
  logic [8:0]  stackEndQ;
  logic [6:0]  cfg_ff, nxt_cfg;
  logic        self_detect_fail_flag_ff, nxt_self_detect_fail_flag;
  logic [15:0] rd_ff, nxt_rd;
  logic        rdRes_ff, nxt_rdRes;
  logic [15:0] cfgView;
  logic [4:0]  layer_ff, nxt_layer;
  logic        stackEndBits [`STACK_DEPTH];
  seq_state_t  st_ff, nxt_st;
  logic        pc_ff, nxt_pc;
  logic [8:0]  ps_ff, nxt_ps;
  logic [2:0]  os_ff, nxt_os;
  logic        ap_ff, nxt_ap;
  logic        seqOn, burstOn;

  assign isWrite = cmd_word[`DIR_BIT];
  assign regSel  = cmd_word[`DIR_BIT:`ADDR_LSB];
  assign payload = cmd_word[`DATA_MSB:0];
  assign cfgWr  = cmd_valid && isWrite && !regSel[5] &&
                  regSel[4:0] == `ADDR_CONFIG;
  assign chanWr = cmd_valid && isWrite && !regSel[5] &&
                  regSel[4:0] == `ADDR_CHANNEL;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gRange
      assign rangeWr[g] = cmd_valid && isWrite && !regSel[5] &&
                          regSel[4:0] == `ADDR_RANGE_A1 + 5'(g);
      reg9 #(.RESET_VAL(`RANGE_RESET)) uRange (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .load    (rangeWr[g]),
        .din     (payload),
        .q       (rangeQ[g])
      );
    end
  endgenerate
  reg9 #(.RESET_VAL(9'h0_00)) uChan (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .load    (chanWr),
    .din     (payload),
    .q       (chanQ)
  );

  // Stack holds the pair codes in 7:0; the end marker is bit 8.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `STACK_DEPTH; i++) begin
        stack_ff[i] <= (i < 8) ? 9'(i * 17) : 9'h0_00;
      end
    end else if (cmd_valid && isWrite && regSel[5]) begin
      stack_ff[regSel[4:0]] <= payload;
    end
  end
  always_comb begin
    for (int i = 0; i < `STACK_DEPTH; i++) begin
      stackEndBits[i] = stack_ff[i][8];
    end
  end
  assign stackEndQ = stack_ff[layer_ff];

  // Configuration bits 6:0 excluding the flag; flag taken from the check.
  always_comb begin
    nxt_cfg  = cfg_ff;
    nxt_self_detect_fail_flag = self_test_fail;
    if (cfgWr) begin
      nxt_cfg = payload[`CFG_BURST:0];
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ff  <= 7'(`CFG_RESET);
      self_detect_fail_flag_ff <= 1'b0;
    end else begin
      cfg_ff  <= nxt_cfg;
      self_detect_fail_flag_ff <= nxt_self_detect_fail_flag;
    end
  end
  assign cfgView = {2'b00, `ADDR_CONFIG, 1'b0, self_detect_fail_flag_ff, cfg_ff};

  // Read arming: the word is prepared now and shown on the next read.
  always_comb begin
    nxt_rd    = rd_ff;
    nxt_rdRes = rdRes_ff;
    if (cmd_valid && !isWrite) begin
      nxt_rdRes = 1'b0;
      nxt_rd    = {regSel, 9'h0_00};
      if (regSel[5]) begin
        nxt_rd = {regSel, stack_ff[regSel[4:0]]};
      end else begin
        case (regSel[4:0])
          `ADDR_RESULTS: nxt_rdRes = 1'b1;
          `ADDR_CONFIG:  nxt_rd = cfgView;
          `ADDR_CHANNEL: nxt_rd = {regSel, chanQ};
          5'h0_4, 5'h0_5, 5'h0_6, `ADDR_RANGE_B2:
            nxt_rd = {regSel, rangeQ[regSel[1:0]]};
          `ADDR_STATUS:  nxt_rd = {regSel, 1'b0, status_word};
          default:       nxt_rd = {regSel, 9'h0_00};
        endcase
      end
    end else if (read_done) begin
      nxt_rdRes = 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_ff    <= 16'h0000;
      rdRes_ff <= 1'b1;
    end else begin
      rd_ff    <= nxt_rd;
      rdRes_ff <= nxt_rdRes;
    end
  end

  // Hardware mode ignores the register so pins keep control.
  assign seqOn   = sw_mode && cfg_ff[`CFG_SEQ];
  assign burstOn = sw_mode && cfg_ff[`CFG_BURST];

  // Conversion stepping over channel pairs.
  always_comb begin
    nxt_st    = st_ff;
    nxt_layer = layer_ff;
    nxt_pc    = 1'b0;
    nxt_ps    = ps_ff;
    nxt_os    = sw_mode ? cfg_ff[`CFG_OS_MSB:`CFG_OS_LSB] : 3'h0;
    nxt_ap    = sw_mode &&
                (cfg_ff[`CFG_STATUS] || cfg_ff[`CFG_CRC]);
    case (st_ff)
      SEQ_IDLE: begin
        if (convert_start_pulse) begin
          nxt_pc = 1'b1;
          if (seqOn) begin
            nxt_ps = {1'b0, stackEndQ[7:0]};
            nxt_st = (burstOn && !stackEndBits[layer_ff]) ?
                     SEQ_RUN : SEQ_IDLE;
            nxt_layer = stackEndBits[layer_ff] ? 5'h0_0 :
                        5'(layer_ff + 5'h0_1);
          end else begin
            nxt_ps = {1'b0, chanQ[7:0]};
          end
        end
      end
      SEQ_RUN: begin
        if (pair_done) begin
          nxt_pc    = 1'b1;
          nxt_ps    = {1'b0, stackEndQ[7:0]};
          nxt_st    = stackEndBits[layer_ff] ? SEQ_IDLE : SEQ_RUN;
          nxt_layer = stackEndBits[layer_ff] ? 5'h0_0 :
                      5'(layer_ff + 5'h0_1);
        end
      end
      default: nxt_st = SEQ_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff    <= SEQ_IDLE;
      layer_ff <= 5'h0_0;
      pc_ff    <= 1'b0;
      ps_ff    <= 9'h0_00;
      os_ff    <= 3'h0;
      ap_ff    <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      layer_ff <= nxt_layer;
      pc_ff    <= nxt_pc;
      ps_ff    <= nxt_ps;
      os_ff    <= nxt_os;
      ap_ff    <= nxt_ap;
    end
  end

  // Readback is registered so the output comes from a flip-flop.
  logic [15:0] cfgOut_ff;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfgOut_ff <= 16'h0000;
    end else begin
      cfgOut_ff <= cfgView;
    end
  end

  assign read_data          = rd_ff;
  assign read_is_results    = rdRes_ff;
  assign main_configuration = cfgOut_ff;
  assign pair_convert       = pc_ff;
  assign pair_select        = ps_ff;
  assign oversample_ratio   = os_ff;
  assign append_status      = ap_ff;
endmodule
`default_nettype wire

// file: adc_cmd_cfg.svh
// Constants for the ADC command decoder and configuration register.
`ifndef ADC_CMD_CFG_SVH
`define ADC_CMD_CFG_SVH
`define DIR_BIT        15
`define ADDR_MSB       14
`define ADDR_LSB       9
`define DATA_MSB       8
`define ADDR_RESULTS   5'h0_0
`define ADDR_RESERVED  5'h0_1
`define ADDR_CONFIG    5'h0_2
`define ADDR_CHANNEL   5'h0_3
`define ADDR_RANGE_A1  5'h0_4
`define ADDR_RANGE_B2  5'h0_7
`define ADDR_STATUS    5'h0_8
`define CFG_RESET      16'h0000
`define RANGE_RESET    9'h0_FF
`define CFG_SELF_DETECT_FAIL_FLAG       7
`define CFG_BURST      6
`define CFG_SEQ        5
`define CFG_OS_MSB     4
`define CFG_OS_LSB     2
`define CFG_STATUS     1
`define CFG_CRC        0
`define STACK_DEPTH    32
`endif

// file: adc_cmd_pkg.sv
// Types shared by the ADC command decoder.
package adc_cmd_pkg;
  typedef enum logic [1:0] {
    RD_RESULTS,
    RD_REGISTER,
    RD_STACK
  } read_src_t;
  typedef enum logic {
    SEQ_IDLE,
    SEQ_RUN
  } seq_state_t;
endpackage

// file: reg9.sv
// Nine-bit loadable register with a reset value.
`timescale 1ns/10ps
`default_nettype none
module reg9 #(
  parameter logic [8:0] RESET_VAL = 9'h0_00
) (
  input  wire logic       sys_clk, // Clock.
  input  wire logic       nrst,    // Async reset, low.
  input  wire logic       load,    // Load strobe.
  input  wire logic [8:0] din,     // Load data.
  output logic      [8:0] q        // Stored value.
);
  logic [8:0] q_ff;
  logic [8:0] nxt_q;
  always_comb begin
    nxt_q = load ? din : q_ff;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q_ff <= RESET_VAL;
    end else begin
      q_ff <= nxt_q;
    end
  end
  assign q = q_ff;
endmodule
`default_nettype wire

// file: adc_cfg_monitor.sv
// Port assertions for the ADC command decoder.
`timescale 1ns/10ps
`default_nettype none
module adc_cfg_monitor (
  input wire logic        sys_clk,             // Clock.
  input wire logic        nrst,                // Reset, low.
  input wire logic        cmd_valid,           // Strobe.
  input wire logic [15:0] cmd_word,            // Command.
  input wire logic        sw_mode,             // Soft mode.
  input wire logic        self_test_fail,      // Self check.
  input wire logic        convert_start_pulse, // Convert.
  input wire logic [15:0] read_data,           // Read word.
  input wire logic        read_is_results,     // Results armed.
  input wire logic [15:0] main_configuration,  // Config.
  input wire logic        pair_convert,        // Pair start.
  input wire logic [2:0]  oversample_ratio,    // Ratio.
  input wire logic        append_status        // Append.
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire logic cfgWr = cmd_valid && cmd_word[15:9] == 7'h02 + 7'h40;
  sequence rd_seq;
    cmd_valid && !cmd_word[15];
  endsequence
  sequence cfg_wr;
    cfgWr;
  endsequence
  results_arm_a:
    assert property (rd_seq ##0 cmd_word[14:9] == 6'h00 |=> read_is_results)
      else $error("results not armed");
  reg_arm_a:
    assert property (rd_seq ##0 cmd_word[14:9] != 6'h00 |=> !read_is_results)
      else $error("results left armed");
  read_addr_a:
    assert property (rd_seq ##0 cmd_word[14:9] != 6'h00
      |=> read_data[15:9] == {1'b0, $past(cmd_word[14:9])})
      else $error("read address field wrong");
  cfg_write_a:
    assert property (cfg_wr |-> ##2
      main_configuration[6:0] == $past(cmd_word[6:0], 2))
      else $error("config write lost");
  cfg_only_a:
    assert property ($changed(main_configuration[6:0]) |-> $past(cfgWr, 2))
      else $error("config changed without write");
  self_detect_fail_flag_flag_a:
    assert property ($stable(self_test_fail)[*4]
      |-> main_configuration[7] == self_test_fail)
      else $error("self detect flag wrong");
  mode_gate_a:
    assert property ((!sw_mode)[*3]
      |-> oversample_ratio == 3'h0 && !append_status)
      else $error("settings act outside soft mode");
  os_follow_a:
    assert property ((sw_mode && !cmd_valid &&
      $stable(main_configuration))[*3]
      |-> oversample_ratio == main_configuration[4:2])
      else $error("ratio code wrong");
  conv_start_a:
    assert property (convert_start_pulse |=> pair_convert)
      else $error("no pair conversion");
endmodule
bind adc_command_decoder_config adc_cfg_monitor mon (.sys_clk, .nrst,
  .cmd_valid, .cmd_word, .sw_mode, .self_test_fail, .convert_start_pulse,
  .read_data, .read_is_results, .main_configuration, .pair_convert,
  .oversample_ratio, .append_status);
`default_nettype wire

// file: host_model.sv
// Host controller model issuing command words.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic        sys_clk,   // Clock.
  output logic             cmd_valid, // Strobe.
  output logic      [15:0] cmd_word   // Command.
);
  initial begin
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
  end
  // Strobe stays up so words can follow on consecutive cycles.
  task automatic send(input logic [15:0] w);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_word = w;
  endtask
  // Idle lines show the inverted word so stale data never looks valid.
  task automatic idle;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_word = ~cmd_word;
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the ADC command decoder.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic        sys_clk = 1'b0, nrst = 1'b0, sw_mode = 1'b0, read_done = 1'b0;
  logic        self_test_fail = 1'b0, convert_start_pulse = 1'b0;
  logic        pair_done = 1'b0, rdTake = 1'b0, cmd_valid, read_is_results;
  logic        pair_convert, append_status;
  logic [15:0] cmd_word, read_data, main_configuration;
  logic [8:0]  pair_select, m [64];
  logic [7:0]  status_word = 8'h00;
  logic [5:0]  ra;
  logic [2:0]  oversample_ratio;
  logic [16:0] e, rq [$];
  logic [7:0]  pq [$];
  int          fail_count = 0, check_count = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  host_model host (.sys_clk, .cmd_valid, .cmd_word);
  adc_command_decoder_config uut (.sys_clk, .nrst, .cmd_valid, .cmd_word,
    .read_done, .sw_mode, .self_test_fail, .convert_start_pulse, .pair_done,
    .status_word, .read_data, .read_is_results, .main_configuration,
    .pair_convert, .pair_select, .oversample_ratio, .append_status);
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [16:0] expect_rd(input logic [5:0] a);
    logic [8:0] d;
    d = m[a];
    if (a == 6'h02) d[7] = self_test_fail;
    if (a == 6'h08) d = {1'b0, status_word};
    return (a == 6'h00) ? 17'h1_0000 : {2'b00, a, d};
  endfunction
  task automatic wr(input logic [5:0] a, input logic [8:0] d);
    host.send({1'b1, a, d});
    if (a[5] || a inside {[6'h02:6'h07]}) m[a] = d;
    if (a == 6'h02) m[a][8:7] = 2'b00;
  endtask
  task automatic rd(input logic [5:0] a);
    host.send({1'b0, a, 9'($urandom)});
    rq.push_back(expect_rd(a));
  endtask
  task automatic pulse(input logic [7:0] c);
    pq.push_back(c);
    @(negedge sys_clk) convert_start_pulse = 1'b1;
    @(negedge sys_clk) convert_start_pulse = 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic do_reset;
    @(negedge sys_clk) nrst = 1'b0;
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    foreach (m[i]) m[i] = (i inside {[4:7]}) ? 9'h0ff : 9'h000;
    for (int i = 0; i < 8; i++) m[32 + i] = 9'(i * 17);
    `CHK(read_is_results, 1'b1)
    `CHK(main_configuration, 16'h0000)
  endtask
  always @(posedge sys_clk) rdTake <= cmd_valid && !cmd_word[15];
  always @(negedge sys_clk) begin
    if (rdTake && rq.size() > 0) begin
      e = rq.pop_front();
      `CHK(read_is_results, e[16])
      if (!e[16]) `CHK(read_data, e[15:0])
    end
    if (pair_convert) begin
      e[7:0] = (pq.size() > 0) ? pq.pop_front() : 8'hxx;
      `CHK(pair_select[7:0], e[7:0])
    end
    pair_done <= pair_convert;
    if (++cyc == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    status_word = 8'($urandom(32'h2d73));
    self_test_fail = 1'($urandom);
    do_reset();
    for (int a = 0; a < 64; a++) rd(6'(a));
    host.idle();
    repeat (60) begin
      sw_mode = 1'($urandom);
      ra = 6'($urandom);
      if (ra == 6'h02) ra = 6'h01;
      wr(ra, 9'($urandom));
      wr(6'h02, 9'($urandom));
      rd(ra);
      rd(6'h02);
      host.idle();
      e = expect_rd(6'h02);
      `CHK(main_configuration[8:0], e[8:0])
      `CHK(oversample_ratio, sw_mode ? e[4:2] : 3'h0)
      `CHK(append_status, sw_mode && (e[1] || e[0]))
    end
    @(negedge sys_clk) read_done = 1'b1;
    @(negedge sys_clk) read_done = 1'b0;
    `CHK(read_is_results, 1'b1)
    // Flip the check result so the flag is seen at both levels.
    self_test_fail = !self_test_fail;
    do_reset();
    sw_mode = 1'b1;
    wr(6'h03, 9'h05a);
    wr(6'h22, 9'h122);
    wr(6'h02, 9'h000);
    host.idle();
    pulse(8'h5a);
    wr(6'h02, 9'h020);
    host.idle();
    for (int i = 0; i < 3; i++) pulse(8'(i * 17));
    wr(6'h02, 9'h060);
    host.idle();
    pq.push_back(8'h00);
    pq.push_back(8'h11);
    pulse(8'h22);
    `CHK(pq.size(), 0)
    `CHK(main_configuration[7], self_test_fail)
    wrap_up();
  end
endmodule
`default_nettype wire
